// >>> sdf_bist.sv
// Purpose: Supply self-test engine walking every diagnostic path
// Assumes: Core answers set and pin requests combinationally
// Notes: Run never aborts; result is posted once at the end
`default_nettype none
module sdf_bist
  import sdf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  sdf_bist_if.eng bus
);
  sdf_bist_state_e state_q;
  logic [3:0] idx_q;
  logic fail_q;
  logic last;

  // Thermistor paths are not judged while that reference is off
  function automatic logic is_therm(input logic [3:0] i);
    is_therm = (i >= 4'(CMP_THERM_OVER)) && (i <= 4'(CMP_THERM_OSC));
  endfunction

  assign last = (idx_q == 4'(SDF_NPATH - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= SDF_IDLE;
    else if (clk_en)
    begin
      case (state_q)
        SDF_IDLE:
          if (bus.start)
            state_q <= SDF_FORCE;
        SDF_FORCE:
          state_q <= SDF_CHECK;
        SDF_CHECK:
          state_q <= SDF_CLEAR;
        SDF_CLEAR:
          state_q <= last ? SDF_FINISH : SDF_FORCE;
        SDF_FINISH:
          state_q <= SDF_IDLE;
        default:
          state_q <= SDF_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      idx_q <= 4'h0;
    else if (clk_en)
    begin
      if (state_q == SDF_IDLE)
        idx_q <= 4'h0;
      else if (state_q == SDF_CLEAR && !last)
        idx_q <= idx_q + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fail_q <= 1'b0;
    else if (clk_en)
    begin
      if (state_q == SDF_IDLE && bus.start)
        fail_q <= 1'b0;
      else if (state_q == SDF_CHECK && !(is_therm(idx_q) && !bus.therm_en))
        fail_q <= fail_q | !(bus.set_req[idx_q] && bus.pin_req);
    end
  end

  // Force one path at a time
  always_comb
  begin
    bus.force_path = '0;
    if (state_q == SDF_FORCE || state_q == SDF_CHECK)
      bus.force_path[idx_q] = 1'b1;
  end

  assign bus.clear_all = (state_q == SDF_CLEAR) && !bus.skip_clear;
  assign bus.busy = (state_q != SDF_IDLE);
  assign bus.fail_set = (state_q == SDF_FINISH) && fail_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_forced;
    state_q == SDF_FORCE && clk_en;
  endsequence
  sequence s_checked;
    state_q == SDF_CHECK;
  endsequence

  a_force_one_hot: assert property (
    bus.busy |-> $countones(bus.force_path) <= 1)
    else $error("more than one path forced");
  a_force_then_check: assert property (
    s_forced |=> s_checked ##0 bus.force_path[idx_q])
    else $error("check did not follow force on same path");
  a_skip_no_clear: assert property (
    bus.skip_clear |-> !bus.clear_all)
    else $error("clear issued with skip option");
  a_no_self_start: assert property (
    $rose(bus.busy) |-> $past(bus.start))
    else $error("self-test started without command");
  a_walk_complete: assert property (
    state_q == SDF_FINISH |-> idx_q == 4'(SDF_NPATH - 1))
    else $error("run ended before last path");
endmodule // sdf_bist
`default_nettype wire

// >>> sdf_bist_if.sv
// Purpose: Carrier between the flag core and the self-test engine
// Assumes: Single clock domain
// Notes: Engine drives force, clear and result; core answers with requests
`default_nettype none
interface sdf_bist_if
  import sdf_pkg::*;
;
  logic start;
  logic skip_clear;
  logic therm_en;
  logic [SDF_NPATH-1:0] force_path;
  logic [SDF_NPATH-1:0] set_req;
  logic pin_req;
  logic clear_all;
  logic busy;
  logic fail_set;
  modport eng (
    input start, skip_clear, therm_en, set_req, pin_req,
    output force_path, clear_all, busy, fail_set
  );
  modport core (
    output start, skip_clear, therm_en, set_req, pin_req,
    input force_path, clear_all, busy, fail_set
  );
endinterface : sdf_bist_if
`default_nettype wire

// >>> sdf_host_model.sv
// Purpose: Host side of the register port, single-cycle strobes
// Assumes: Read data stands only in the cycle after the read strobe
// Notes: Idle address shows the inverse of the last access, idle data the inverse of the last write
`default_nettype none
module sdf_host_model
  import sdf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [SDF_DW-1:0] reg_rdata,
  output logic [SDF_AW-1:0] reg_addr,
  output logic [SDF_DW-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Starts come only from host writes
  task automatic wr(input logic [SDF_AW-1:0] a, input logic [SDF_DW-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [SDF_AW-1:0] a, output logic [SDF_DW-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule // sdf_host_model
`default_nettype wire

// >>> sdf_pkg.sv
// Purpose: Shared constants for the supply diagnostics and self-test block
// Assumes: 8-bit register port, 4-bit word address
// Notes: Path index equals flag position in the combined flag vector
`default_nettype none
package sdf_pkg;
  localparam int SDF_AW = 4;
  localparam int SDF_DW = 8;
  // Comparator inputs; 0..13 are also self-test paths
  localparam int SDF_NCMP = 16;
  localparam int SDF_NPATH = 15;
  localparam int CMP_ANALOG_OVER = 0;
  localparam int CMP_ANALOG_OSC = 1;
  localparam int CMP_DIGITAL_OVER = 2;
  localparam int CMP_COMM_OVER = 3;
  localparam int CMP_COMM_UNDER = 4;
  localparam int CMP_REFM_OPEN = 5;
  localparam int CMP_DGND_OPEN = 6;
  localparam int CMP_CGND_OPEN = 7;
  localparam int CMP_THERM_OVER = 8;
  localparam int CMP_THERM_UNDER = 9;
  localparam int CMP_THERM_OSC = 10;
  localparam int CMP_NEG_UNDER = 11;
  localparam int CMP_REF_OSC = 12;
  localparam int CMP_REFM_OSC = 13;
  localparam int CMP_ANALOG_UNDER = 14;
  localparam int CMP_DIGITAL_UNDER = 15;
  // Flag 14 is the self-test fail flag (status_b bit 6)
  localparam int FLAG_SELFTEST_FAIL = 14;
  localparam int STATUS_B_BASE = 8;
  // Register offsets
  localparam logic [3:0] OFS_STATUS_A = 4'h0;
  localparam logic [3:0] OFS_STATUS_B = 4'h1;
  localparam logic [3:0] OFS_STATUS_C = 4'h2;
  localparam logic [3:0] OFS_CTRL = 4'h3;
  localparam logic [3:0] OFS_MASK_A = 4'h4;
  localparam logic [3:0] OFS_MASK_B = 4'h5;
  localparam logic [3:0] OFS_MASK_C = 4'h6;
  // Control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_SKIP_CLEAR = 1;
  localparam int CTRL_THERM_EN = 2;
  localparam int CTRL_PIN_EN = 3;
  localparam logic [2:0] CTRL_RESET = 3'h6;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int IND_BIT = 0;
  typedef enum logic [2:0] {
    SDF_IDLE, SDF_FORCE, SDF_CHECK, SDF_CLEAR, SDF_FINISH
  } sdf_bist_state_e;
endpackage : sdf_pkg
`default_nettype wire

// >>> sdf_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pin levels
// Assumes: Inputs are slow levels, no multi-bit coherence needed
// Notes: First stage feeds only the second stage
`default_nettype none
module sdf_sync
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else if (clk_en)
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // sdf_sync
`default_nettype wire

// >>> sdf_top.sv
// Purpose: Supply fault flags, digital reset requests and self-test
// Assumes: Comparator levels arrive asynchronously on cmp_raw
// Notes: Register port, 8-bit data, read data one cycle after strobe
// How it works
// - Detection runs in active or sleep mode
// - Supply failures set their matching flags
// - Analog undervoltage disables rail, resets digital
// - Indicator records analog undervoltage reset
// - Digital undervoltage triggers a digital reset
// - Thermistor faults also force temperature registers
// - Open pins set dedicated flags
// - Over/under may raise oscillation flags
// - Self-test starts only on host command
// - Self-test covers every flag path
// - Force failure into each path
// - Check set and pin requests active
// - Clear all status registers, release pin
// - Repeat force, check, clear per path
// - Start bit launches; result at end
// - Skip option keeps forced flags
//
// The address map and the address-and-strobe port were decided locally.
`default_nettype none
module sdf_top
  import sdf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [SDF_AW-1:0] reg_addr,
  input wire logic [SDF_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [SDF_DW-1:0] reg_rdata,
  input wire logic [SDF_NCMP-1:0] cmp_raw,
  input wire logic mode_run,
  output logic fault_pin_n,
  output logic irq,
  output logic dig_reset_req,
  output logic digital_rail_off,
  output logic temp_fault_force_all
);
  logic [1:0] rst_pipe_q;
  logic rst_n;
  logic [SDF_NCMP:0] sync_v;
  logic det_en;
  logic [SDF_NCMP-1:0] det;
  logic [SDF_NPATH-1:0] set_req;
  logic [SDF_NPATH-1:0] clr_v;
  logic [SDF_NPATH-1:0] fl_q;
  logic [SDF_NPATH-1:0] fl_d;
  logic [SDF_NPATH-1:0] keep_v;
  logic ind_q;
  logic ind_d;
  logic [2:0] ctrl_q;
  logic [7:0] mask_a_q;
  logic [7:0] mask_b_q;
  logic [7:0] mask_c_q;
  logic [SDF_DW-1:0] rdata_q;
  logic fault_pin_n_q;
  logic dig_reset_req_q;
  logic rail_off_q;
  logic temp_force_q;
  logic analog_under_q;
  logic reset_evt;
  logic wr_a;
  logic wr_b;
  logic wr_c;
  logic wr_ctrl;
  logic [7:0] status_a;
  logic [7:0] status_b;
  logic [7:0] status_c;

  sdf_bist_if bif ();

  // Release reset synchronously so no flop leaves reset on a skewed edge
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rst_pipe_q <= 2'b00;
    else if (clk_en)
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
  end
  assign rst_n = rst_pipe_q[1];

  sdf_sync #(
    .W(SDF_NCMP + 1)
  ) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d({mode_run, cmp_raw}),
    .q(sync_v)
  );

  sdf_bist u_bist (
    .clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .bus(bif.eng)
  );

  // Background detection gated by operating mode
  assign det_en = sync_v[SDF_NCMP];
  // Forced failure joins the comparator output
  assign det = ({SDF_NCMP{det_en}} & sync_v[SDF_NCMP-1:0])
             | {2'b00, bif.force_path[SDF_NPATH-2:0]};

  // Flag set requests, one per path
  // Open-pin paths map straight to status_a
  always_comb
  begin
    set_req = det[SDF_NPATH-1:0];
    // Fail flag path is forced as well
    set_req[FLAG_SELFTEST_FAIL] = bif.force_path[FLAG_SELFTEST_FAIL]
                                | bif.fail_set;
    // Over faults may also show as oscillation
    set_req[CMP_ANALOG_OSC] = det[CMP_ANALOG_OSC] | det[CMP_ANALOG_OVER];
    set_req[CMP_THERM_OSC] = det[CMP_THERM_OSC] | det[CMP_THERM_OVER]
                           | det[CMP_THERM_UNDER];
  end
  // Pin request follows any flag request
  assign bif.set_req = set_req;
  assign bif.pin_req = |set_req;

  assign wr_a = reg_wr && (reg_addr == OFS_STATUS_A);
  assign wr_b = reg_wr && (reg_addr == OFS_STATUS_B);
  assign wr_c = reg_wr && (reg_addr == OFS_STATUS_C);
  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);

  // Undervoltage on either rail resets the digital core
  assign reset_evt = det[CMP_ANALOG_UNDER] && !analog_under_q;

  // Self-test wipes every status register; digital reset wipes status_a and status_b
  always_comb
  begin
    clr_v = '0;
    if (wr_a)
      clr_v[7:0] = reg_wdata;
    if (wr_b)
      clr_v[SDF_NPATH-1:STATUS_B_BASE] = reg_wdata[6:0];
    if (bif.clear_all || reset_evt || det[CMP_DIGITAL_UNDER])
      clr_v = '1;
  end

  // Sticky flags; a set in the clearing cycle wins
  assign fl_d = (fl_q & ~clr_v) | set_req;
  assign keep_v = fl_q & ~clr_v;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      fl_q <= '0;
    else if (clk_en)
      fl_q <= fl_d;
  end

  // Indicator outlives the reset it records
  assign ind_d = (ind_q & ~(wr_c && reg_wdata[IND_BIT])
               & ~bif.clear_all) | reset_evt;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ind_q <= 1'b0;
    else if (clk_en)
      ind_q <= ind_d;
  end

  // Analog undervoltage: rail off and reset, no flag
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      analog_under_q <= 1'b0;
      rail_off_q <= 1'b0;
      dig_reset_req_q <= 1'b0;
    end
    else if (clk_en)
    begin
      analog_under_q <= det[CMP_ANALOG_UNDER];
      rail_off_q <= det[CMP_ANALOG_UNDER];
      dig_reset_req_q <= reset_evt || det[CMP_DIGITAL_UNDER];
    end
  end

  // Thermistor faults drive temperature registers to all ones
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      temp_force_q <= 1'b0;
    else if (clk_en)
      temp_force_q <= |set_req[CMP_THERM_OSC:CMP_THERM_OVER];
  end

  // Pin released once the flags are cleared
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_pin_n_q <= 1'b1;
    else if (clk_en)
      fault_pin_n_q <= !(ctrl_q[CTRL_PIN_EN - 1] && (|fl_d));
  end

  // Control holds skip, thermistor enable, pin enable
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= CTRL_RESET;
    else if (clk_en && wr_ctrl)
      ctrl_q <= reg_wdata[CTRL_PIN_EN:CTRL_SKIP_CLEAR];
  end

  // Start only from a host write of one
  assign bif.start = wr_ctrl && reg_wdata[CTRL_START] && !bif.busy;
  assign bif.skip_clear = ctrl_q[CTRL_SKIP_CLEAR - 1];
  assign bif.therm_en = ctrl_q[CTRL_THERM_EN - 1];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_a_q <= MASK_RESET;
      mask_b_q <= MASK_RESET;
      mask_c_q <= MASK_RESET;
    end
    else if (clk_en && reg_wr)
    begin
      if (reg_addr == OFS_MASK_A)
        mask_a_q <= reg_wdata;
      if (reg_addr == OFS_MASK_B)
        mask_b_q <= reg_wdata;
      if (reg_addr == OFS_MASK_C)
        mask_c_q <= reg_wdata;
    end
  end

  assign status_a = fl_q[7:0];
  assign status_b = {1'b0, fl_q[SDF_NPATH-1:STATUS_B_BASE]};
  assign status_c = {7'h00, ind_q};

  // Unmapped addresses read as zero
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (clk_en)
    begin
      rdata_q <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          OFS_STATUS_A: rdata_q <= status_a;
          OFS_STATUS_B: rdata_q <= status_b;
          OFS_STATUS_C: rdata_q <= status_c;
          OFS_CTRL: rdata_q <= {4'h0, ctrl_q, bif.busy};
          OFS_MASK_A: rdata_q <= mask_a_q;
          OFS_MASK_B: rdata_q <= mask_b_q;
          OFS_MASK_C: rdata_q <= mask_c_q;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = |((status_a & mask_a_q) | (status_b & mask_b_q)
               | (status_c & mask_c_q));
  assign fault_pin_n = fault_pin_n_q;
  assign dig_reset_req = dig_reset_req_q;
  assign digital_rail_off = rail_off_q;
  assign temp_fault_force_all = temp_force_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_detect_sets_flag: assert property (
    clk_en |=> ((fl_q & $past(set_req)) == $past(set_req)))
    else $error("detection did not set its flag");
  a_flag_sticky: assert property (
    1'b1 |=> ((fl_q & $past(keep_v)) == $past(keep_v)))
    else $error("flag dropped without clear");
  a_mode_gates_det: assert property (
    (!det_en && bif.force_path == '0) |-> det == '0)
    else $error("detection active outside run modes");
  a_therm_forces_temp: assert property (
    (clk_en && |set_req[CMP_THERM_OSC:CMP_THERM_OVER]) |=> temp_force_q)
    else $error("temperature registers not forced");
  a_analog_reset_ind: assert property (
    (clk_en && reset_evt) |=> (ind_q && dig_reset_req_q && rail_off_q))
    else $error("analog undervoltage reset not recorded");
  a_digital_reset: assert property (
    (clk_en && det[CMP_DIGITAL_UNDER]) |=> dig_reset_req_q)
    else $error("digital undervoltage gave no reset");
  a_pin_follows_req: assert property (
    (clk_en && bif.pin_req && ctrl_q[CTRL_PIN_EN - 1]) |=> !fault_pin_n)
    else $error("fault pin not asserted on request");
  a_bist_clear_all: assert property (
    (clk_en && bif.clear_all) |=> ((fl_q & ~$past(set_req)) == '0
                                   && (!ind_q || $past(reset_evt))))
    else $error("self-test clear left flags set");
endmodule // sdf_top
`default_nettype wire

// >>> supply_diag_fault_bist_tb.sv
// Purpose: Self-checking bench for supply flags, resets and self-test
// Assumes: Comparator levels settle within three edges
// Notes: Expected flags come from an integer model of the paths
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; \
  if (32'(got) !== 32'(ex)) begin num_errors++; \
  $display("FAIL %s exp %0h got %0h", nm, 32'(ex), got); end end
module supply_diag_fault_bist_tb
  import sdf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rstn, mode_run, reg_wr, reg_rd;
  logic clk_en;
  logic fault_pin_n, irq, dig_reset_req, digital_rail_off;
  logic temp_fault_force_all;
  logic [SDF_AW-1:0] reg_addr;
  logic [SDF_DW-1:0] reg_wdata, reg_rdata, rdat;
  logic [SDF_NCMP-1:0] cmp_raw;
  logic [31:0] r;
  int num_errors = 0;
  int tests_run = 0;
  int pin_falls = 0;
  int rst_cycles = 0;
  int exp_q[$];
  logic pin_d = 1'b1;
  sdf_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_raw(cmp_raw),
    .mode_run(mode_run), .fault_pin_n(fault_pin_n), .irq(irq),
    .dig_reset_req(dig_reset_req), .digital_rail_off(digital_rail_off),
    .temp_fault_force_all(temp_fault_force_all));
  sdf_host_model host_u (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Sampled mid-cycle so registered outputs have settled
  always @(negedge ref_clk)
  begin
    if (pin_d === 1'b1 && fault_pin_n === 1'b0)
      pin_falls++;
    if (dig_reset_req === 1'b1)
      rst_cycles++;
    pin_d <= fault_pin_n;
  end
  function automatic int exp_flags(input int c);
    int f;
    f = c & 32'h3fff;
    if (c[0])
      f |= 32'h2;
    if (c[8] || c[9])
      f |= 32'h400;
    return f;
  endfunction
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic clear_flags();
    host_u.wr(OFS_STATUS_A, 8'hff);
    host_u.wr(OFS_STATUS_B, 8'hff);
  endtask
  task automatic hold(input logic [15:0] c, input int n);
    cmp_raw <= c;
    repeat (n) @(posedge ref_clk);
    cmp_raw <= '0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic detect(input logic [15:0] c);
    int e;
    int ex_v;
    e = exp_flags(c);
    exp_q.push_back(e & 32'hff);
    exp_q.push_back((e >> 8) & 32'h7f);
    cmp_raw <= c;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("temp_force", (c & 16'h0700) != 0, temp_fault_force_all)
    `CHK("pin_detect", e == 0, fault_pin_n)
    @(posedge ref_clk);
    cmp_raw <= '0;
    repeat (3) @(posedge ref_clk);
    host_u.rd(OFS_STATUS_A, rdat);
    // Pop once: the compare macro evaluates its expectation twice
    ex_v = exp_q.pop_front();
    `CHK("status_a", ex_v, rdat)
    host_u.rd(OFS_STATUS_B, rdat);
    ex_v = exp_q.pop_front();
    `CHK("status_b", ex_v, rdat)
    clear_flags();
    host_u.rd(OFS_STATUS_A, rdat);
    `CHK("status_a_clr", 0, rdat)
    @(negedge ref_clk);
    `CHK("pin_clr", 1, fault_pin_n)
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    $display("FAIL watchdog exp done got timeout");
    end_of_test();
  end
  initial
  begin
    rstn = 1'b0;
    clk_en = 1'b1;
    mode_run = 1'b1;
    cmp_raw = '0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    r = $urandom(50);
    @(negedge ref_clk);
    `CHK("pin_reset", 1, fault_pin_n)
    `CHK("irq_reset", 0, irq)
    host_u.wr(4'h7, 8'hff);
    for (int a = 0; a < 16; a++)
    begin
      host_u.rd(4'(a), rdat);
      `CHK("reg_reset", (a == 3) ? 12 : 0, rdat)
    end
    for (int i = 0; i < 14; i++)
      detect(16'(1 << i));
    for (int i = 0; i < 3; i++)
      detect(16'($urandom) & 16'h3fff);
    // Detection gated by the run mode
    mode_run <= 1'b0;
    hold(16'h0008, 6);
    mode_run <= 1'b1;
    host_u.rd(OFS_STATUS_A, rdat);
    `CHK("mode_off", 0, rdat)
    hold(16'h1008, 5);
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom;
      host_u.wr(OFS_MASK_A, r[7:0]);
      host_u.wr(OFS_MASK_B, r[15:8]);
      @(negedge ref_clk);
      `CHK("irq_mask", (r & 32'h1008) != 0, irq)
    end
    host_u.wr(OFS_MASK_A, 8'h08);
    host_u.wr(OFS_MASK_B, 8'h00);
    host_u.wr(OFS_STATUS_A, 8'h08);
    @(negedge ref_clk);
    `CHK("irq_w1c", 0, irq)
    host_u.rd(OFS_STATUS_B, rdat);
    `CHK("status_b_kept", 8'h10, rdat)
    host_u.wr(OFS_MASK_A, 8'h00);
    clear_flags();
    hold(16'h0008, 5);
    cmp_raw <= 16'h8000;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("dig_reset", 1, dig_reset_req)
    hold(16'h8000, 1);
    host_u.rd(OFS_STATUS_A, rdat);
    `CHK("dig_under_clr", 0, rdat)
    hold(16'h0008, 5);
    rst_cycles = 0;
    cmp_raw <= 16'h4000;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("rail_off", 1, digital_rail_off)
    `CHK("reset_pulse", 1, rst_cycles)
    host_u.rd(OFS_STATUS_A, rdat);
    `CHK("an_under_clr", 0, rdat)
    host_u.rd(OFS_STATUS_C, rdat);
    `CHK("indicator", 1, rdat)
    hold(16'h4000, 1);
    @(negedge ref_clk);
    `CHK("rail_on", 0, digital_rail_off)
    host_u.wr(OFS_MASK_C, 8'h01);
    @(negedge ref_clk);
    `CHK("irq_c", 1, irq)
    host_u.wr(OFS_MASK_C, 8'h00);
    // Clock enable low freezes sync and flags alike
    clk_en <= 1'b0;
    hold(16'h0008, 5);
    clk_en <= 1'b1;
    host_u.rd(OFS_STATUS_A, rdat);
    `CHK("freeze", 0, rdat)
    pin_falls = 0;
    host_u.wr(OFS_CTRL, 8'h0d);
    host_u.wr(OFS_CTRL, 8'h0d);
    repeat (43) @(posedge ref_clk);
    host_u.rd(OFS_CTRL, rdat);
    `CHK("busy_end", 8'h0c, rdat)
    `CHK("pin_toggles", 15, pin_falls)
    `CHK("pin_run_end", 1, fault_pin_n)
    for (int a = 0; a < 3; a++)
    begin
      host_u.rd(4'(a), rdat);
      `CHK("run_clear", 0, rdat)
    end
    host_u.wr(OFS_CTRL, 8'h0f);
    repeat (44) @(posedge ref_clk);
    host_u.rd(OFS_CTRL, rdat);
    `CHK("busy_last", 8'h0f, rdat)
    repeat (5) @(posedge ref_clk);
    host_u.rd(OFS_STATUS_A, rdat);
    `CHK("skip_a", 8'hff, rdat)
    host_u.rd(OFS_STATUS_B, rdat);
    `CHK("skip_b", 8'h7f, rdat)
    @(negedge ref_clk);
    `CHK("pin_skip", 0, fault_pin_n)
    // Pin enable off releases the pin while flags stay set
    host_u.wr(OFS_CTRL, 8'h00);
    repeat (2) @(negedge ref_clk);
    `CHK("pin_off", 1, fault_pin_n)
    end_of_test();
  end
endmodule // supply_diag_fault_bist_tb
`default_nettype wire
